// ### logic/csl_pkg.sv
// Package: constants and types for the configuration sync and startup block
package csl_pkg;
	localparam int CSL_CLK_MHZ = 25;
	localparam int CSL_POR_US = 2000;
	localparam int CSL_INIT_DLY_US = 100;
	localparam int CSL_POR_CYC = CSL_POR_US * CSL_CLK_MHZ;
	localparam int CSL_INIT_CYC = CSL_INIT_DLY_US * CSL_CLK_MHZ;
	localparam int CSL_RST_MIN_NS = 200;
	localparam int CSL_RST_MIN_OLD_NS = 300;
	localparam logic [31:0] CSL_SYNC_WORD = 32'hAA995566;
	localparam logic [31:0] CSL_HDR_PASSTHRU = 32'h30010001;
	localparam logic [31:0] CSL_HDR_CMD = 32'h30008001;
	localparam logic [31:0] CSL_DUMMY_WORD = 32'hFFFFFFFF;
	localparam int CSL_PASS_LAT = 40;
	localparam logic [2:0] CSL_PH_COMPLETE = 3'h4;
	localparam logic [2:0] CSL_PH_TRISTATE = 3'h5;
	localparam logic [2:0] CSL_PH_SETRESET = 3'h6;
	localparam logic [2:0] CSL_PH_WRENABLE = 3'h6;
	localparam logic [2:0] CSL_PH_ON_COMPLETE = 3'h7;
	// AXI register byte offsets
	localparam logic [7:0] CSL_A_CTRL = 8'h00;
	localparam logic [7:0] CSL_A_PHASE = 8'h04;
	localparam logic [7:0] CSL_A_STATUS = 8'h08;
	localparam logic [7:0] CSL_A_CMD = 8'h0C;
	// Control field positions
	localparam int CSL_C_PIPE = 0;
	localparam int CSL_C_DRIVE = 1;
	localparam int CSL_C_WAIT = 2;
	localparam int CSL_C_SERIAL = 3;
	localparam int CSL_C_BYTE = 4;
	localparam int CSL_C_CLKSEL = 5;
	localparam logic [6:0] CSL_CTRL_RST = 7'h08;
	localparam logic [11:0] CSL_PHASE_RST = {CSL_PH_WRENABLE, CSL_PH_SETRESET,
		CSL_PH_TRISTATE, CSL_PH_COMPLETE};
	localparam logic [1:0] CSL_RESP_OK = 2'h0;
	localparam logic [1:0] CSL_RESP_ERR = 2'h2;
	typedef enum logic [1:0] {
		CSL_CLK_CFG, CSL_CLK_USER, CSL_CLK_SCAN
	} csl_clksel_t;
endpackage

// ### logic/csl_axi_if.sv
// Interface: register fields passed between bus slave and core
`timescale 1ns/1ps
interface csl_axi_if;
	logic [6:0] ctrl;
	logic [11:0] phase;
	logic [31:0] status;
	logic [31:0] cmd;
	modport slave (output ctrl, output phase, input status, input cmd);
	modport core (input ctrl, input phase, output status, output cmd);
endinterface

// ### logic/csl_axi_regs.sv
// AXI4-Lite register slave for the configuration front end
`timescale 1ns/1ps
module csl_axi_regs import csl_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	csl_axi_if.slave rf
);
	typedef struct packed {
		logic aw_have;
		logic [7:0] aw_a;
		logic w_have;
		logic [31:0] w_d;
		logic [3:0] w_s;
		logic bv;
		logic [1:0] br;
		logic rv;
		logic [31:0] rd;
		logic [1:0] rr;
		logic [6:0] ctrl;
		logic [11:0] phase;
	} csl_regs_t;
	csl_regs_t s_r, s_nxt;

	always_comb begin
		s_nxt = s_r;
		if (awvalid && !s_r.aw_have) begin
			s_nxt.aw_have = 1'b1;
			s_nxt.aw_a = awaddr;
		end
		if (wvalid && !s_r.w_have) begin
			s_nxt.w_have = 1'b1;
			s_nxt.w_d = wdata;
			// Strobes travel with the data word, not with the later commit
			s_nxt.w_s = wstrb;
		end
		if (s_r.bv && bready)
			s_nxt.bv = 1'b0;
		// Write once both halves are held and no response is pending
		if (s_r.aw_have && s_r.w_have && !s_r.bv) begin
			s_nxt.aw_have = 1'b0;
			s_nxt.w_have = 1'b0;
			s_nxt.bv = 1'b1;
			s_nxt.br = CSL_RESP_OK;
			case (s_r.aw_a)
			CSL_A_CTRL: if (s_r.w_s[0]) s_nxt.ctrl = s_r.w_d[6:0];
			CSL_A_PHASE: begin
				if (s_r.w_s[0]) s_nxt.phase[7:0] = s_r.w_d[7:0];
				if (s_r.w_s[1]) s_nxt.phase[11:8] = s_r.w_d[11:8];
			end
			CSL_A_STATUS, CSL_A_CMD: ;
			default: s_nxt.br = CSL_RESP_ERR;
			endcase
		end
		if (s_r.rv && rready)
			s_nxt.rv = 1'b0;
		if (arvalid && !s_r.rv) begin
			s_nxt.rv = 1'b1;
			s_nxt.rr = CSL_RESP_OK;
			case (araddr)
			CSL_A_CTRL: s_nxt.rd = {25'h0, s_r.ctrl};
			CSL_A_PHASE: s_nxt.rd = {20'h00000, s_r.phase};
			CSL_A_STATUS: s_nxt.rd = rf.status;
			CSL_A_CMD: s_nxt.rd = rf.cmd;
			default: begin
				s_nxt.rd = 32'h00000000;
				s_nxt.rr = CSL_RESP_ERR;
			end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_r <= '0;
			s_r.ctrl <= CSL_CTRL_RST;
			s_r.phase <= CSL_PHASE_RST;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	assign awready = !s_r.aw_have;
	assign wready = !s_r.w_have;
	assign bvalid = s_r.bv;
	assign bresp = s_r.br;
	assign arready = !s_r.rv;
	assign rvalid = s_r.rv;
	assign rdata = s_r.rd;
	assign rresp = s_r.rr;
	assign rf.ctrl = s_r.ctrl;
	assign rf.phase = s_r.phase;
endmodule

// ### logic/csl_core.sv
// Top: configuration sync detection, packet decode and startup sequencing
//
// How it works
// - After power-up wait 2 ms then 0.1 ms before raising ready.
// - Restart pin low resets the state machine; release restarts config.
// - Ready stays low while restart is held low.
// - Frame error drives ready low during the faulty frame.
// - Pipeline option adds one register on sensed completion input.
// - Completion pin is open drain; active-drive option drives it high.
// - Startup runs on config clock unless user or scan clock chosen.
// - Completion and three globals release on selectable startup phases.
// - Wait option stalls startup until sensed completion goes high.
// - Ignore all data until 32-bit sync word AA995566 arrives.
// - In byte mode the byte's MSB sits on data pin zero.
// - A slipped bit loads nothing more; ready high, completion low.
// - Before sync no packet decodes and serial output stays high.
// - Pass-through data reaches serial output 40 config clocks later.
// - Pass-through writes act only in serial modes.
// - Header 30010001 writes next word to pass-through register.
// - Header 30008001 writes next word to command register.
// - CRC error pulls ready low until a restart pulse.
// - Each serial output bit changes on config clock rising edge.
// - Serial output carries only pass-through register data.
`timescale 1ns/1ps
module csl_core import csl_pkg::*; #(
	parameter int POR_CYCLES = CSL_POR_CYC,
	parameter int PASS_LAT = CSL_PASS_LAT
) (
	input wire logic CLK_SYS,
	input wire logic RESET,
	input wire logic CE,
	input wire logic CFG_CLOCK,
	input wire logic RESTART_N,
	input wire logic SER_DIN,
	input wire logic [7:0] BYTE_DIN,
	input wire logic USER_CLOCK,
	input wire logic SCAN_CLOCK,
	input wire logic COMPLETE_IN,
	input wire logic FRAME_ERR,
	input wire logic CRC_ERR,
	output logic READY_O,
	output logic READY_OE_N,
	output logic COMPLETE_O,
	output logic COMPLETE_OE_N,
	output logic SER_DOUT,
	output logic GLOBAL_TRISTATE,
	output logic GLOBAL_SET_RESET,
	output logic GLOBAL_WRITE_ENABLE,
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);
	if (POR_CYCLES < 1 || POR_CYCLES > 16777216 || PASS_LAT < 2
			|| PASS_LAT > 64) begin : g_chk
		$error("csl_core: unsupported parameter value");
	end

	typedef enum logic [2:0] {
		CSL_POR, CSL_INITD, CSL_HUNT, CSL_HDR, CSL_DATA, CSL_STALL,
		CSL_START, CSL_ERR
	} csl_state_t;

	typedef struct packed {
		logic [1:0] cfg_clock_s;
		logic [1:0] rst_s;
		logic [1:0] sdi_s;
		logic [15:0] bdi_s;
		logic [1:0] uclk_s;
		logic [1:0] jclk_s;
		logic [1:0] cmp_s;
		logic [1:0] fe_s;
		logic [1:0] crc_s;
		logic cfg_clock_d;
		logic uclk_d;
		logic jclk_d;
		logic cmp_p;
		csl_state_t st;
		logic [23:0] cnt;
		logic [31:0] sh;
		logic [4:0] bitc;
		logic is_pass;
		logic [31:0] cmd;
		logic [63:0] pipe;
		logic [31:0] pass_w;
		logic [5:0] pass_left;
		logic [2:0] sphase;
		logic rdy;
		logic cmp;
		logic global_tristate;
		logic global_set_reset;
		logic global_write_enable;
		logic dout;
	} csl_state_r_t;
	csl_state_r_t s_r, s_nxt;

	csl_axi_if rf ();

	csl_axi_regs u_regs (
		.clk(CLK_SYS), .rst(RESET), .ce(CE),
		.awaddr(S_AXI_AWADDR), .awvalid(S_AXI_AWVALID),
		.awready(S_AXI_AWREADY), .wdata(S_AXI_WDATA),
		.wstrb(S_AXI_WSTRB), .wvalid(S_AXI_WVALID),
		.wready(S_AXI_WREADY), .bresp(S_AXI_BRESP),
		.bvalid(S_AXI_BVALID), .bready(S_AXI_BREADY),
		.araddr(S_AXI_ARADDR), .arvalid(S_AXI_ARVALID),
		.arready(S_AXI_ARREADY), .rdata(S_AXI_RDATA),
		.rresp(S_AXI_RRESP), .rvalid(S_AXI_RVALID),
		.rready(S_AXI_RREADY), .rf(rf)
	);

	// Phase reached or tied to completion going high
	function automatic logic phase_hit(input logic [2:0] sel,
			input logic [2:0] ph, input logic cmp_done);
		phase_hit = (sel == CSL_PH_ON_COMPLETE) ? cmp_done : (ph >= sel);
	endfunction

	////////////////////////////////////////////////////////////////////////
	logic cfg_edge, su_edge, cmp_sense, byte_mode, wrd_done;
	logic [31:0] sh_next;
	logic [7:0] byte_sw;

	always_comb begin
		cfg_edge = s_r.cfg_clock_s[1] && !s_r.cfg_clock_d;
		// Startup clock source selectable
		case (csl_clksel_t'(rf.ctrl[CSL_C_CLKSEL +: 2]))
		CSL_CLK_USER: su_edge = s_r.uclk_s[1] && !s_r.uclk_d;
		CSL_CLK_SCAN: su_edge = s_r.jclk_s[1] && !s_r.jclk_d;
		default: su_edge = cfg_edge;
		endcase
		// Optional extra stage for slow completion pin
		cmp_sense = rf.ctrl[CSL_C_PIPE] ? s_r.cmp_p : s_r.cmp_s[1];
		byte_mode = rf.ctrl[CSL_C_BYTE] && !rf.ctrl[CSL_C_SERIAL];
		// Pin zero carries the byte's MSB
		for (int i = 0; i < 8; i++)
			byte_sw[7 - i] = s_r.bdi_s[8 + i];
		sh_next = byte_mode ? {s_r.sh[23:0], byte_sw}
			: {s_r.sh[30:0], s_r.sdi_s[1]};
		wrd_done = byte_mode ? (s_r.bitc == 5'h03) : (s_r.bitc == 5'h1F);
	end

	always_comb begin
		s_nxt = s_r;
		s_nxt.cfg_clock_s = {s_r.cfg_clock_s[0], CFG_CLOCK};
		s_nxt.rst_s = {s_r.rst_s[0], RESTART_N};
		s_nxt.sdi_s = {s_r.sdi_s[0], SER_DIN};
		s_nxt.bdi_s = {s_r.bdi_s[7:0], BYTE_DIN};
		s_nxt.uclk_s = {s_r.uclk_s[0], USER_CLOCK};
		s_nxt.jclk_s = {s_r.jclk_s[0], SCAN_CLOCK};
		s_nxt.cmp_s = {s_r.cmp_s[0], COMPLETE_IN};
		s_nxt.fe_s = {s_r.fe_s[0], FRAME_ERR};
		s_nxt.crc_s = {s_r.crc_s[0], CRC_ERR};
		s_nxt.cfg_clock_d = s_r.cfg_clock_s[1];
		s_nxt.uclk_d = s_r.uclk_s[1];
		s_nxt.jclk_d = s_r.jclk_s[1];
		if (cfg_edge)
			s_nxt.cmp_p = s_r.cmp_s[1];

		// Output shifter, one bit per config clock rising edge
		if (cfg_edge) begin
			s_nxt.pipe = {s_r.pipe[62:0], 1'b1};
			s_nxt.dout = s_r.pipe[PASS_LAT - 2];
			if (s_r.pass_left != 6'h00) begin
				// Only pass-through words feed the output
				s_nxt.pipe[0] = s_r.pass_w[31];
				s_nxt.pass_w = {s_r.pass_w[30:0], 1'b0};
				s_nxt.pass_left = s_r.pass_left - 6'h01;
			end
		end

		case (s_r.st)
		CSL_POR: begin
			s_nxt.cnt = s_r.cnt + 24'h000001;
			if (s_r.cnt == 24'(POR_CYCLES - 1)) begin
				s_nxt.st = CSL_INITD;
				s_nxt.cnt = '0;
			end
		end
		CSL_INITD: begin
			s_nxt.cnt = s_r.cnt + 24'h000001;
			if (s_r.cnt == 24'(CSL_INIT_CYC - 1)) begin
				s_nxt.st = CSL_HUNT;
				s_nxt.rdy = 1'b1;
			end
		end
		CSL_HUNT: if (cfg_edge) begin
			s_nxt.sh = sh_next;
			// Sliding compare aligns the word boundary
			if (sh_next == CSL_SYNC_WORD) begin
				s_nxt.st = CSL_HDR;
				s_nxt.bitc = '0;
			end
		end
		CSL_HDR, CSL_DATA: if (cfg_edge) begin
			s_nxt.sh = sh_next;
			s_nxt.bitc = s_r.bitc + 5'h01;
			if (wrd_done) begin
				s_nxt.bitc = '0;
				if (s_r.st == CSL_HDR) begin
					// Unknown headers are skipped; a slipped bit lands here
					// forever, so nothing loads and ready stays high
					if (sh_next == CSL_HDR_PASSTHRU) begin
						s_nxt.st = CSL_DATA;
						s_nxt.is_pass = 1'b1;
					end else if (sh_next == CSL_HDR_CMD) begin
						s_nxt.st = CSL_DATA;
						s_nxt.is_pass = 1'b0;
					end
				end else begin
					s_nxt.st = CSL_HDR;
					if (!s_r.is_pass)
						s_nxt.cmd = sh_next;
					else if (rf.ctrl[CSL_C_SERIAL]) begin
						s_nxt.pass_w = sh_next;
						s_nxt.pass_left = 6'h20;
					end
					if (!s_r.is_pass && sh_next != 32'h00000000)
						s_nxt.st = CSL_STALL;
				end
			end
		end
		CSL_STALL: begin
			s_nxt.sphase = '0;
			s_nxt.st = CSL_START;
		end
		CSL_START: if (su_edge) begin
			// Hold the sequence before I/O wakes until completion seen
			if (!(rf.ctrl[CSL_C_WAIT] && s_r.sphase >= 3'h4 && !cmp_sense)
					&& s_r.sphase != 3'h6)
				s_nxt.sphase = s_r.sphase + 3'h1;
			if (phase_hit(rf.phase[2:0], s_r.sphase, cmp_sense))
				s_nxt.cmp = 1'b1;
			if (phase_hit(rf.phase[5:3], s_r.sphase, cmp_sense))
				s_nxt.global_tristate = 1'b0;
			if (phase_hit(rf.phase[8:6], s_r.sphase, cmp_sense))
				s_nxt.global_set_reset = 1'b0;
			if (phase_hit(rf.phase[11:9], s_r.sphase, cmp_sense))
				s_nxt.global_write_enable = 1'b1;
		end
		CSL_ERR: s_nxt.rdy = 1'b0;
		default: s_nxt.st = CSL_POR;
		endcase

		// Frame error pulls ready low only for the affected frame
		if (s_r.st == CSL_HDR || s_r.st == CSL_DATA)
			s_nxt.rdy = !s_r.fe_s[1];
		// CRC error latches until restart
		if (s_r.crc_s[1] && s_r.st != CSL_POR && s_r.st != CSL_INITD) begin
			s_nxt.st = CSL_ERR;
			s_nxt.rdy = 1'b0;
		end

		// Restart low: back to unsynchronised, ready held low
		if (!s_r.rst_s[1] && s_r.st != CSL_POR) begin
			s_nxt.st = CSL_INITD;
			s_nxt.cnt = '0;
			s_nxt.rdy = 1'b0;
			s_nxt.bitc = '0;
			s_nxt.sh = '0;
			s_nxt.pass_left = '0;
			s_nxt.pipe = '1;
			s_nxt.dout = 1'b1;
			s_nxt.cmp = 1'b0;
			s_nxt.global_tristate = 1'b1;
			s_nxt.global_set_reset = 1'b1;
			s_nxt.global_write_enable = 1'b0;
		end else if (!s_r.rst_s[1])
			s_nxt.cnt = '0;
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			s_r <= '0;
			s_r.st <= CSL_POR;
			s_r.rst_s <= 2'h3;
			s_r.pipe <= '1;
			s_r.dout <= 1'b1;
			s_r.global_tristate <= 1'b1;
			s_r.global_set_reset <= 1'b1;
		end else if (CE) begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign rf.status = {24'h000000, 2'h0, s_r.cmp_s[1], s_r.rdy, 1'b0,
		s_r.st};
	assign rf.cmd = s_r.cmd;

	always_comb begin
		READY_O = 1'b0;
		READY_OE_N = s_r.rdy;
		SER_DOUT = s_r.dout;
		GLOBAL_TRISTATE = s_r.global_tristate;
		GLOBAL_SET_RESET = s_r.global_set_reset;
		GLOBAL_WRITE_ENABLE = s_r.global_write_enable;
		// Open drain unless active drive is chosen
		COMPLETE_O = s_r.cmp && rf.ctrl[CSL_C_DRIVE];
		COMPLETE_OE_N = s_r.cmp && !rf.ctrl[CSL_C_DRIVE];
	end

	a_ready_low_restart: assert property (@(posedge CLK_SYS)
		disable iff (RESET) CE && !s_r.rst_s[1] |=> !s_r.rdy)
		else $error("ready high during restart");
	a_no_out_unsync: assert property (@(posedge CLK_SYS)
		disable iff (RESET) s_r.st == CSL_HUNT && s_r.pass_left == 0
		&& $past(s_r.st) == CSL_HUNT |-> s_r.dout)
		else $error("serial out low before sync");
	a_crc_latch: assert property (@(posedge CLK_SYS)
		disable iff (RESET) s_r.st == CSL_ERR && s_r.rst_s[1] && CE
		|=> s_r.st == CSL_ERR && !s_r.rdy)
		else $error("crc error state left");
	a_sync_hdr: assert property (@(posedge CLK_SYS)
		disable iff (RESET) CE && s_r.st == CSL_HUNT && cfg_edge
		&& sh_next == CSL_SYNC_WORD && s_r.rst_s[1] && !s_r.crc_s[1]
		|=> s_r.st == CSL_HDR && s_r.bitc == 0)
		else $error("sync word not taken");
	a_pass_serial: assert property (@(posedge CLK_SYS)
		disable iff (RESET) CE && $rose(s_r.pass_left != 0)
		|-> rf.ctrl[CSL_C_SERIAL])
		else $error("pass write outside serial");
	a_cmp_pipe: assert property (@(posedge CLK_SYS)
		disable iff (RESET) CE && cfg_edge
		|=> s_r.cmp_p == $past(s_r.cmp_s[1]))
		else $error("completion pipe stage skipped");
	a_drive_mode: assert property (@(posedge CLK_SYS)
		disable iff (RESET) !s_r.cmp |-> !COMPLETE_O && !COMPLETE_OE_N)
		else $error("completion released early");
	a_por_ready: assert property (@(posedge CLK_SYS)
		disable iff (RESET) s_r.st == CSL_POR |-> !s_r.rdy)
		else $error("ready during power-on");
endmodule

// ### dv/csl_src_model.sv
// Bitstream source model: drives the link clock and serial data
`timescale 1ns/1ps
module csl_src_model (
	output logic cfg_clock,
	output logic ser_din,
	output logic [7:0] byte_din
);
	// No write strobe or chip select is driven, so neither toggles
	int rise_cnt;

	initial begin
		cfg_clock = 1'b0;
		ser_din = 1'b1;
		byte_din = 8'h00;
		rise_cnt = 0;
	end

	////////////////////////////////////////////////////////////////////////
	// One bit per 320 ns, MSB first; clock stands low between words
	// Data settles 80 ns before the rise and holds 240 ns after it,
	// which covers the block's two-stage sampling of the clock pin
	task automatic send_word(input logic [31:0] w);
		#10;
		for (int i = 31; i >= 0; i--) begin
			#73 ser_din = w[i];
			#80 cfg_clock = 1'b1;
			rise_cnt++;
			#160 cfg_clock = 1'b0;
			#7;
		end
		// Released line shows no stale value
		#80 ser_din = ~ser_din;
	endtask

	// Byte-wide: most significant byte first, its MSB on pin zero
	task automatic send_bytes(input logic [31:0] w);
		#10;
		for (int i = 3; i >= 0; i--) begin
			#73;
			for (int j = 0; j < 8; j++)
				byte_din[j] = w[8 * i + 7 - j];
			#80 cfg_clock = 1'b1;
			rise_cnt++;
			#160 cfg_clock = 1'b0;
			#7;
		end
		#80 byte_din = ~byte_din;
	endtask
endmodule

// ### dv/csl_core_tb.sv
// Testbench: reset timing, sync hunt, pass-through, startup and registers
`timescale 1ns/1ps
module csl_core_tb import csl_pkg::*; ();
	localparam int POR = 20;
	localparam logic [31:0] PDATA = 32'hC3A50F81;
	localparam logic [31:0] BCMD = 32'h0137C5A8;
	logic clk_sys, reset, restart_n, frame_err, crc_err;
	logic [7:0] awaddr, araddr;
	logic awvalid, wvalid, bready, arvalid, rready;
	logic [31:0] wdata, d, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	logic awready, wready, bvalid, arready, rvalid;
	logic cfg_clock, ser_din, ready_o, ready_oe_n, complete_o, complete_oe_n;
	logic ser_dout, global_tristate, global_set_reset, global_write_enable, watch, seen_low;
	logic [7:0] byte_din;
	int n_mismatch, check_count, base;
	int cyc = 0;

	csl_src_model i_src (.cfg_clock(cfg_clock), .ser_din(ser_din),
		.byte_din(byte_din));

	// Completion pin has a pull-up; block's own drive wins when enabled
	csl_core #(.POR_CYCLES(POR), .PASS_LAT(CSL_PASS_LAT)) i_dut (
		.CLK_SYS(clk_sys), .RESET(reset), .CE(1'b1),
		.CFG_CLOCK(cfg_clock), .RESTART_N(restart_n), .SER_DIN(ser_din),
		.BYTE_DIN(byte_din), .USER_CLOCK(1'b0), .SCAN_CLOCK(1'b0),
		.COMPLETE_IN(complete_oe_n ? 1'b1 : complete_o),
		.FRAME_ERR(frame_err), .CRC_ERR(crc_err),
		.READY_O(ready_o), .READY_OE_N(ready_oe_n),
		.COMPLETE_O(complete_o), .COMPLETE_OE_N(complete_oe_n),
		.SER_DOUT(ser_dout), .GLOBAL_TRISTATE(global_tristate),
		.GLOBAL_SET_RESET(global_set_reset), .GLOBAL_WRITE_ENABLE(global_write_enable),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
		.S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready)
	);

	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	////////////////////////////////////////////////////////////////////////
	// Reporting
	task automatic end_sim();
		$display("Checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
			input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Hang guard: whole run is well under this many cycles
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_mismatch++;
			end_sim();
		end
	end

	// Sole driver of seen_low: cleared whenever nobody is watching
	always @(posedge clk_sys) begin
		if (!watch)
			seen_low <= 1'b0;
		else if (ser_dout !== 1'b1)
			seen_low <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite master
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v,
			output logic [1:0] rsp);
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= v;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (awvalid && awready === 1'b1)
				awvalid <= 1'b0;
			if (wvalid && wready === 1'b1)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		rsp = bresp;
		bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v,
			output logic [1:0] rsp);
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (arvalid && arready === 1'b1)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		v = rdata;
		rsp = rresp;
		rready <= 1'b0;
	endtask

	task automatic wait_ready();
		int n;
		n = 0;
		while (ready_oe_n !== 1'b1 && n < 3000) begin
			@(posedge clk_sys);
			n++;
		end
		chk("ready_up", 32'h1, 32'(ready_oe_n));
	endtask

	task automatic send(input logic [31:0] w);
		i_src.send_word(w);
	endtask

	// Unsynced stream must leave the serial output high throughout
	task automatic quiet(input logic [31:0] w);
		watch <= 1'b1;
		send(w);
		send(32'h00000000);
		send(CSL_DUMMY_WORD);
		send(CSL_DUMMY_WORD);
		watch <= 1'b0;
		@(posedge clk_sys);
		chk("dout_quiet", 32'h0, 32'(seen_low));
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		reset <= 1'b1;
		restart_n <= 1'b1;
		frame_err <= 1'b0;
		crc_err <= 1'b0;
		{awaddr, araddr, wdata, wstrb} <= '0;
		{awvalid, wvalid, bready, arvalid, rready, watch} <= '0;
		{n_mismatch, check_count} = '0;
		repeat (12) @(posedge clk_sys);
		chk("ready_rst", 32'h0, 32'(ready_oe_n));
		chk("dout_rst", 32'h1, 32'(ser_dout));
		chk("gts_rst", 32'h1, 32'(global_tristate));
		chk("gwe_rst", 32'h0, 32'(global_write_enable));
		reset <= 1'b0;
		repeat (2400) @(posedge clk_sys);
		chk("ready_por", 32'h0, 32'(ready_oe_n));
		wait_ready();
		$display("Test power-on done");
		axi_rd(CSL_A_CTRL, d, r);
		chk("ctrl_rst", 32'(CSL_CTRL_RST), d);
		axi_rd(CSL_A_PHASE, d, r);
		chk("phase_rst", 32'(CSL_PHASE_RST), d);
		axi_rd(8'h10, d, r);
		chk("rd_unmap", 32'(CSL_RESP_ERR), 32'(r));
		chk("rd_unmap_data", 32'h0, d);
		axi_wr(8'h10, 32'h1, r);
		chk("wr_unmap", 32'(CSL_RESP_ERR), 32'(r));
		axi_rd(CSL_A_STATUS, d, r);
		chk("status_ready", 32'h1, 32'(d[4]));
		$display("Test registers done");
		quiet(CSL_HDR_PASSTHRU);
		$display("Test hunt done");
		base = i_src.rise_cnt;
		fork
			begin
				send(CSL_DUMMY_WORD);
				send(CSL_SYNC_WORD);
				send(CSL_HDR_PASSTHRU);
				send(PDATA);
				repeat (3) send(CSL_DUMMY_WORD);
			end
			begin
				wait (i_src.rise_cnt == base + 127 + CSL_PASS_LAT);
				#240;
				chk("dout_early", 32'h1, 32'(ser_dout));
				for (int k = 0; k < 32; k++) begin
					wait (i_src.rise_cnt == base + 128 + CSL_PASS_LAT + k);
					#240;
					chk("dout_bit", 32'(PDATA[31-k]), 32'(ser_dout));
				end
			end
		join
		$display("Test pass-through done");
		send(CSL_HDR_CMD);
		send(32'h00000001);
		send(CSL_DUMMY_WORD);
		send(CSL_DUMMY_WORD);
		axi_rd(CSL_A_CMD, d, r);
		chk("cmd_reg", 32'h1, d);
		chk("gts_run", 32'h0, 32'(global_tristate));
		chk("gsr_run", 32'h0, 32'(global_set_reset));
		chk("gwe_run", 32'h1, 32'(global_write_enable));
		chk("cmp_open", 32'h1, 32'(complete_oe_n));
		axi_wr(CSL_A_CTRL, 32'h0000000A, r);
		repeat (4) @(posedge clk_sys);
		chk("cmp_drive_o", 32'h1, 32'(complete_o));
		chk("cmp_drive_oe", 32'h0, 32'(complete_oe_n));
		$display("Test startup done");
		send(CSL_SYNC_WORD);
		send(CSL_HDR_PASSTHRU);
		// Restart held 400 ns, above the shared-pin minimum
		@(posedge clk_sys);
		restart_n <= 1'b0;
		repeat (10) @(posedge clk_sys);
		chk("ready_restart", 32'h0, 32'(ready_oe_n));
		chk("gts_restart", 32'h1, 32'(global_tristate));
		restart_n <= 1'b1;
		wait_ready();
		quiet(CSL_DUMMY_WORD);
		$display("Test restart done");
		send(CSL_SYNC_WORD);
		fork
			begin
				send(CSL_HDR_CMD);
				send(32'h00000000);
			end
			begin
				repeat (100) @(posedge clk_sys);
				frame_err <= 1'b1;
				repeat (8) @(posedge clk_sys);
				chk("ready_frame", 32'h0, 32'(ready_oe_n));
				frame_err <= 1'b0;
				repeat (8) @(posedge clk_sys);
				chk("ready_after", 32'h1, 32'(ready_oe_n));
			end
		join
		@(posedge clk_sys);
		crc_err <= 1'b1;
		@(posedge clk_sys);
		crc_err <= 1'b0;
		send(CSL_DUMMY_WORD);
		chk("ready_crc", 32'h0, 32'(ready_oe_n));
		$display("Test errors done");
		// Recover from the latched error, then load byte-wide
		@(posedge clk_sys);
		restart_n <= 1'b0;
		repeat (10) @(posedge clk_sys);
		restart_n <= 1'b1;
		axi_wr(CSL_A_CTRL, 32'h00000010, r);
		wait_ready();
		i_src.send_bytes(CSL_SYNC_WORD);
		watch <= 1'b1;
		i_src.send_bytes(CSL_HDR_PASSTHRU);
		i_src.send_bytes(32'h00000000);
		repeat (12) i_src.send_bytes(CSL_DUMMY_WORD);
		watch <= 1'b0;
		@(posedge clk_sys);
		chk("dout_byte", 32'h0, 32'(seen_low));
		i_src.send_bytes(CSL_HDR_CMD);
		i_src.send_bytes(BCMD);
		axi_rd(CSL_A_CMD, d, r);
		chk("cmd_byte", BCMD, d);
		$display("Test byte mode done");
		end_sim();
	end
endmodule
